// ### common/pss_defines.svh
/*
 pfc switching sequencer constants: timing, clamp codes, register map.
 assumes a 200 MHz core clock.
*/
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define PSS_CLK_MHZ 200
`define PSS_T_MINOFF_NS 4000
`define PSS_MINOFF_CYC 10'((`PSS_T_MINOFF_NS * `PSS_CLK_MHZ + 999) / 1000)
`define PSS_T_RESTART_US 200
`define PSS_RESTART_CYC (`PSS_T_RESTART_US * `PSS_CLK_MHZ)
`define PSS_T_TICK_MS 1
`define PSS_TICK_CYC (`PSS_T_TICK_MS * 1000 * `PSS_CLK_MHZ)
`define PSS_QUAL_TICKS 2'h3
`define PSS_T_ZCD_OFF_MS 10
`define PSS_ZCD_OFF_TICKS 5'(`PSS_T_ZCD_OFF_MS / `PSS_T_TICK_MS)
`define PSS_T_HOLD_MS 20
`define PSS_HOLD_TICKS 5'(`PSS_T_HOLD_MS / `PSS_T_TICK_MS)
// ----------------------------------------
// clamp codes: 0..5 = 1.2V..2.7V step 0.3V, 6 = 3.3V
// ----------------------------------------
`define PSS_CLAMP_MIN 3'h0
`define PSS_CLAMP_TOP 3'h5
`define PSS_CLAMP_NORM 3'h6
// ----------------------------------------
// registers (byte addresses) and fields
// ----------------------------------------
`define PSS_REG_CTRL 4'h0
`define PSS_REG_STAT 4'h4
`define PSS_CTRL_EN 0
`define PSS_CTRL_RST 1'b1
`define PSS_ST_GATE 0
`define PSS_ST_BURST 1
`define PSS_ST_HIREC 2
`define PSS_ST_RSDIS 3
`define PSS_ST_ZCDDIS 4
`define PSS_ST_HOLD 5
`define PSS_ST_FSM 11:8
`define PSS_ST_CLAMP 14:12
`endif

// ### common/pss_pkg.sv
/*
 pfc switching sequencer types.
 assumes nothing beyond the defines header.
*/
package pss_pkg;
    // mode pins {a,b}
    typedef enum logic [1:0] {
        PSS_M_SEQ = 2'h0,
        PSS_M_AS = 2'h1,
        PSS_M_RAPID = 2'h2,
        PSS_M_STBY = 2'h3
    } pss_mode_t;
    typedef enum logic [3:0] {
        PSS_S_IDLE = 4'h1,
        PSS_S_QUAL = 4'h2,
        PSS_S_BURST = 4'h4,
        PSS_S_RUN = 4'h8
    } pss_state_t;
    // comparator flags as they travel through the synchroniser
    typedef struct packed {
        logic mode_a;
        logic mode_b;
        logic rail_low;
        logic rail_high;
        logic rms_ok;
        logic rms_high;
        logic zcd_low;
        logic ramp_err;
        logic ton_cap;
        logic oc;
        logic plim;
        logic line_present;
        logic line_sense;
    } pss_flags_t;
endpackage

// ### design/pss_sequencer.sv
/*
 pfc switching sequencer: burst/normal gating, zero-current and restart
 triggering, min-off after overcurrent, stepped clamp, sag recovery.
 assumes comparator flags from analog, avalon-mm master for registers.
 // Function
 // R1: active standby bursts between 240V and 260V
 // R2: burst starts after three 1ms rms checks
 // R3: active standby fixes clamp at 1.2V
 // R4: sequence start-up mode switches continuously
 // R5: zero-current detection sets gate on
 // R6: ramp reaching error level turns gate off
 // R7: 200us gate off triggers restart
 // R8: overcurrent forces gate low 4us
 // R9: min-off masks zcd, then pulses gate on
 // R10: on-time capped by 3.0V reference
 // R11: overcurrent drives gate low at once
 // R12: power limit clamps at or below previous
 // R13: six clamp steps 1.2V to 2.7V
 // R14: clean cycle raises clamp one step
 // R15: line loss samples rms for recovery type
 // R16: restart timer off until line returns
 // R17: zcd off 10ms after line loss
 // R18: quick line-sense return keeps zcd on
 // R19: error level held 20ms after loss
 // R20: comparator flags pass two flip-flops
 // R21: reset gives normal clamp, clear timers
*/
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_sequencer import pss_pkg::*; #(
    parameter int unsigned RESTART_CYC = `PSS_RESTART_CYC,
    parameter int unsigned TICK_CYC = `PSS_TICK_CYC
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic mode_select_a_in,
    input wire logic mode_select_b_in,
    input wire logic rail_low_in,
    input wire logic rail_high_in,
    input wire logic rms_ok_in,
    input wire logic rms_high_in,
    input wire logic zero_current_sense_in,
    input wire logic ramp_at_error_in,
    input wire logic ontime_cap_input_in,
    input wire logic overcurrent_in,
    input wire logic power_limit_threshold_in,
    input wire logic line_present_in,
    input wire logic line_sense_in,
    output logic boost_gate_out,
    output logic [2:0] clamp_level_out,
    output logic error_hold_out
);
// ----------------------------------------
// input synchroniser
// ----------------------------------------
pss_flags_t raw, s1_reg, f, p_reg;
assign raw = {mode_select_a_in, mode_select_b_in, rail_low_in, rail_high_in,
    rms_ok_in, rms_high_in, zero_current_sense_in, ramp_at_error_in,
    ontime_cap_input_in, overcurrent_in, power_limit_threshold_in,
    line_present_in, line_sense_in};
// two stages, then one more for edge detection
always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        s1_reg <= '0;
        f <= '0;
        p_reg <= '0;
    end else begin
        s1_reg <= raw; // R20
        f <= s1_reg; // R20
        p_reg <= f;
    end
end

wire zcd_edge = f.zcd_low & ~p_reg.zcd_low;
wire plim_edge = f.plim & ~p_reg.plim;
wire lp_fall = p_reg.line_present & ~f.line_present;
wire lp_rise = ~p_reg.line_present & f.line_present;
wire pss_mode_t mode = pss_mode_t'({f.mode_a, f.mode_b});
// ----------------------------------------
// 1ms tick divider
// ----------------------------------------
logic [17:0] tick_cnt_reg;
wire tick = tick_cnt_reg == 18'(TICK_CYC - 1);
always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 18'h1;
end
// ----------------------------------------
// mode state machine
// ----------------------------------------
pss_state_t st_reg, st_next;
logic [1:0] qual_reg, qual_next;
wire qual_hit = tick & f.rms_ok & (qual_reg == `PSS_QUAL_TICKS - 2'h1);
always_comb begin
    st_next = st_reg;
    unique case (st_reg)
        PSS_S_IDLE: begin
            if (mode == PSS_M_AS) st_next = PSS_S_QUAL;
            else if (mode != PSS_M_STBY) st_next = PSS_S_RUN;
        end
        PSS_S_QUAL: begin
            if (mode == PSS_M_STBY) st_next = PSS_S_IDLE;
            else if (mode != PSS_M_AS) st_next = PSS_S_RUN;
            else if (qual_hit) st_next = PSS_S_BURST; // R2
        end
        PSS_S_BURST: begin
            if (mode == PSS_M_STBY) st_next = PSS_S_IDLE;
            else if (mode != PSS_M_AS) st_next = PSS_S_RUN; // R4
        end
        PSS_S_RUN: begin
            if (mode == PSS_M_STBY) st_next = PSS_S_IDLE;
            else if (mode == PSS_M_AS) st_next = PSS_S_QUAL;
        end
        default: st_next = PSS_S_IDLE;
    endcase
end
// consecutive passing checks; a failed check restarts the count
assign qual_next = (st_reg != PSS_S_QUAL) ? 2'h0 :
    (tick ? (f.rms_ok ? qual_reg + 2'h1 : 2'h0) : qual_reg); // R2
always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        st_reg <= PSS_S_IDLE;
        qual_reg <= '0;
    end else begin
        st_reg <= st_next;
        qual_reg <= qual_next;
    end
end
// ----------------------------------------
// burst window and switching permission
// ----------------------------------------
logic burst_on_reg, ctrl_en_reg;
wire burst_on_next = (st_reg != PSS_S_BURST) ? 1'b0 :
    f.rail_low ? 1'b1 : f.rail_high ? 1'b0 : burst_on_reg; // R1
wire allowed = ctrl_en_reg & ((st_reg == PSS_S_RUN) | // R4
    ((st_reg == PSS_S_BURST) & burst_on_reg)); // R1
always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) burst_on_reg <= 1'b0;
    else burst_on_reg <= burst_on_next;
end
// ----------------------------------------
// sag recovery
// ----------------------------------------
logic hi_rec_reg, rs_dis_reg, zcd_dis_reg, hold_reg;
logic [4:0] zt_reg, ht_reg;
wire zt_clr = f.line_present | ~hi_rec_reg | f.line_sense; // R18
wire [4:0] zt_next = zt_clr ? 5'h0 :
    (tick && zt_reg != `PSS_ZCD_OFF_TICKS) ? zt_reg + 5'h1 : zt_reg; // R17
wire [4:0] ht_next = f.line_present ? 5'h0 :
    (tick && ht_reg != `PSS_HOLD_TICKS) ? ht_reg + 5'h1 : ht_reg; // R19
always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        hi_rec_reg <= 1'b0;
        rs_dis_reg <= 1'b0;
        zcd_dis_reg <= 1'b0;
        hold_reg <= 1'b0;
        zt_reg <= '0;
        ht_reg <= '0;
    end else begin
        if (lp_fall) hi_rec_reg <= f.rms_high; // R15
        if (lp_fall) rs_dis_reg <= 1'b1; // R16
        else if (lp_rise) rs_dis_reg <= 1'b0; // R16
        if (zt_reg == `PSS_ZCD_OFF_TICKS && !zt_clr) zcd_dis_reg <= 1'b1; // R17
        else if (lp_rise) zcd_dis_reg <= 1'b0; // R17
        hold_reg <= (ht_reg == `PSS_HOLD_TICKS) & ~f.line_present; // R19
        zt_reg <= zt_next;
        ht_reg <= ht_next;
    end
end
// ----------------------------------------
// gate latch, min-off and restart timers
// ----------------------------------------
logic gate_reg;
logic [9:0] minoff_reg;
logic [17:0] rs_reg;
wire minoff_done = (minoff_reg == 10'h1) & ~f.oc; // R9
wire rs_done = (rs_reg == 18'(RESTART_CYC - 1)) & (minoff_reg == 10'h0);
wire zcd_set = zcd_edge & ~zcd_dis_reg & (minoff_reg == 10'h0); // R5 R9
wire gate_off = f.oc | f.ramp_err | f.ton_cap | ~allowed; // R6 R10 R11
wire gate_on = allowed & ~gate_reg & (zcd_set | rs_done | minoff_done); // R7
wire on_pulse = gate_on & ~gate_off;
wire rs_hold = gate_reg | rs_dis_reg | ~allowed; // R16
always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        gate_reg <= 1'b0;
        minoff_reg <= '0;
        rs_reg <= '0;
    end else begin
        gate_reg <= gate_off ? 1'b0 : (on_pulse | gate_reg); // R5 R11
        if (f.oc) minoff_reg <= `PSS_MINOFF_CYC; // R8
        else if (minoff_reg != 10'h0) minoff_reg <= minoff_reg - 10'h1;
        if (rs_hold || on_pulse) rs_reg <= '0; // R7
        // saturate, so a trigger held back by min-off still fires once it ends
        else if (rs_reg != 18'(RESTART_CYC - 1)) rs_reg <= rs_reg + 18'h1; // R7
    end
end
assign boost_gate_out = gate_reg;
// ----------------------------------------
// error-level clamp selection
// ----------------------------------------
logic [2:0] sel_reg, clamp_reg;
logic pl_seen_reg;
wire as_mode = (st_reg == PSS_S_QUAL) | (st_reg == PSS_S_BURST);
always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        sel_reg <= `PSS_CLAMP_NORM; // R21
        clamp_reg <= `PSS_CLAMP_NORM;
        pl_seen_reg <= 1'b0;
    end else begin
        if (plim_edge) begin
            // step down, never above the previous clamp
            if (sel_reg == `PSS_CLAMP_NORM) sel_reg <= `PSS_CLAMP_TOP; // R12 R13
            else if (sel_reg != `PSS_CLAMP_MIN) sel_reg <= sel_reg - 3'h1; // R12
        end else if (on_pulse && !pl_seen_reg && sel_reg != `PSS_CLAMP_NORM) begin
            sel_reg <= (sel_reg == `PSS_CLAMP_TOP) ? `PSS_CLAMP_NORM : sel_reg + 3'h1; // R14
        end
        // a detection in the gate-on cycle itself still counts
        if (plim_edge) pl_seen_reg <= 1'b1;
        else if (on_pulse) pl_seen_reg <= 1'b0; // R14
        clamp_reg <= as_mode ? `PSS_CLAMP_MIN : sel_reg; // R3
    end
end
assign clamp_level_out = clamp_reg;
assign error_hold_out = hold_reg;
// ----------------------------------------
// avalon-mm slave, one wait state
// ----------------------------------------
logic ack_reg;
logic [31:0] rdata_reg, stat_w;
wire req = avs_read_in | avs_write_in;
always_comb begin
    stat_w = '0;
    stat_w[`PSS_ST_GATE] = gate_reg;
    stat_w[`PSS_ST_BURST] = burst_on_reg;
    stat_w[`PSS_ST_HIREC] = hi_rec_reg;
    stat_w[`PSS_ST_RSDIS] = rs_dis_reg;
    stat_w[`PSS_ST_ZCDDIS] = zcd_dis_reg;
    stat_w[`PSS_ST_HOLD] = hold_reg;
    stat_w[`PSS_ST_FSM] = st_reg;
    stat_w[`PSS_ST_CLAMP] = clamp_reg;
end
wire [31:0] rd_mux = (avs_address_in == `PSS_REG_CTRL) ? {31'h0, ctrl_en_reg} :
    (avs_address_in == `PSS_REG_STAT) ? stat_w : 32'h0;
always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
        ack_reg <= 1'b0;
        rdata_reg <= '0;
        ctrl_en_reg <= `PSS_CTRL_RST;
    end else begin
        ack_reg <= req & ~ack_reg;
        if (avs_read_in && !ack_reg) rdata_reg <= rd_mux;
        if (avs_write_in && ack_reg && avs_address_in == `PSS_REG_CTRL && avs_byteenable_in[0])
            ctrl_en_reg <= avs_writedata_in[`PSS_CTRL_EN];
    end
end
assign avs_waitrequest_out = req & ~ack_reg;
assign avs_readdata_out = rdata_reg;
// ----------------------------------------
// assertions
// ----------------------------------------
default clocking @(posedge core_clk_in); endclocking
default disable iff (rst_in);
property p_oc_off; f.oc |=> !boost_gate_out; endproperty
a_oc_off: assert property (p_oc_off) else $error("gate on after overcurrent"); // R11
property p_minoff; f.oc |=> !boost_gate_out [*8]; endproperty
a_minoff: assert property (p_minoff) else $error("min-off not held"); // R8
property p_mask; (minoff_reg > 10'h1) |=> !gate_reg; endproperty
a_mask: assert property (p_mask) else $error("gate on during min-off"); // R9
property p_ramp; f.ramp_err |=> !boost_gate_out; endproperty
a_ramp: assert property (p_ramp) else $error("gate not cut at error level"); // R6
property p_cap; f.ton_cap |=> !boost_gate_out; endproperty
a_cap: assert property (p_cap) else $error("on-time cap ignored"); // R10
property p_zcd; (zcd_set && allowed && !gate_off && !gate_reg) |=> boost_gate_out; endproperty
a_zcd: assert property (p_zcd) else $error("zcd did not set gate"); // R5
property p_rst; (rs_done && allowed && !gate_off && !gate_reg) |=> boost_gate_out; endproperty
a_rst: assert property (p_rst) else $error("restart did not fire"); // R7
property p_asclamp; as_mode |=> clamp_level_out == `PSS_CLAMP_MIN; endproperty
a_asclamp: assert property (p_asclamp) else $error("standby clamp wrong"); // R3
property p_burst; (st_reg == PSS_S_BURST && !burst_on_reg) |=> !boost_gate_out; endproperty
a_burst: assert property (p_burst) else $error("switching outside burst"); // R1
property p_plim; (plim_edge && sel_reg == `PSS_CLAMP_NORM) |=> sel_reg == `PSS_CLAMP_TOP; endproperty
a_plim: assert property (p_plim) else $error("power limit step wrong"); // R12
property p_hold; f.line_present |=> !error_hold_out; endproperty
a_hold: assert property (p_hold) else $error("hold stuck with line"); // R19
endmodule // pss_sequencer

// ### sim/pss_boost_model.sv
/*
 boost stage model: on-time ramp reaching the error level and the
 zero-current flag once the winding collapses after turn-off.
 assumes the gate comes from the sequencer; on_cycles_in 0 keeps zero-current quiet.
*/
`timescale 1ns/1ps
module pss_boost_model (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic boost_gate_in,
    input wire logic [7:0] on_cycles_in,
    output logic ramp_at_error_out,
    output logic zero_current_sense_out
);
    logic gate_reg;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    // ----------------------------------------
    // time since the last gate edge
    // ----------------------------------------
    assign cnt_next = (gate_reg != boost_gate_in) ? 8'h00 : cnt_reg + 8'(cnt_reg != 8'hff);
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gate_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else begin
            gate_reg <= boost_gate_in;
            cnt_reg <= cnt_next;
        end
    end
    // flags only after the gate has settled, so no stale count leaks through
    assign ramp_at_error_out = boost_gate_in && gate_reg && (cnt_reg >= on_cycles_in);
    assign zero_current_sense_out = !boost_gate_in && !gate_reg && (on_cycles_in != 8'h00) && (cnt_reg >= 8'h0a);
endmodule // pss_boost_model

// ### sim/tb_top.sv
/*
 bench for the switching sequencer: reset, restart, switching, caps,
 overcurrent, clamp stepping, standby bursts, sag recovery.
 assumes the boost model answers the gate; avalon master lives here.
*/
`timescale 1ns/1ps
module tb_top;
    logic core_clk, rst, rd, wr, mode_a, mode_b, rail_lo, rail_hi, rms_ok, rms_hi;
    logic cap, oc, plim, line_p, line_s, ramp, zcd, gate, wait_rq, hold;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, rdata_w;
    logic [7:0] on_cyc;
    logic [2:0] clamp;
    int err_total, total_checks, n;
    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    pss_sequencer #(.RESTART_CYC(40), .TICK_CYC(50)) DUT (.core_clk_in(core_clk), .rst_in(rst),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata_w), .avs_waitrequest_out(wait_rq),
        .mode_select_a_in(mode_a), .mode_select_b_in(mode_b), .rail_low_in(rail_lo), .rail_high_in(rail_hi),
        .rms_ok_in(rms_ok), .rms_high_in(rms_hi), .zero_current_sense_in(zcd), .ramp_at_error_in(ramp),
        .ontime_cap_input_in(cap), .overcurrent_in(oc), .power_limit_threshold_in(plim),
        .line_present_in(line_p), .line_sense_in(line_s), .boost_gate_out(gate),
        .clamp_level_out(clamp), .error_hold_out(hold));
    pss_boost_model boost (.core_clk_in(core_clk), .rst_in(rst), .boost_gate_in(gate),
        .on_cycles_in(on_cyc), .ramp_at_error_out(ramp), .zero_current_sense_out(zcd));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge core_clk); while (wait_rq !== 1'b0);
        rdata = rdata_w;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // counts cycles while the gate holds level v
    task automatic span(input logic v, input int lim);
        n = 0;
        while (gate === v && n < lim) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(32'(gate), 32'h0);
        check(32'(clamp), 32'h6);
        bus(1'b0, 4'h4, 32'h0);
        check(32'(rdata[14:12]), 32'h6);
        check(32'(rdata[5:3]), 32'h0);
        bus(1'b0, 4'h8, 32'h0);
        check(rdata, 32'h0);
        bus(1'b1, 4'h0, 32'h0);
        repeat (60) @(posedge core_clk);
        check(32'(gate), 32'h0);
        bus(1'b1, 4'h0, 32'h1);
    endtask
    task automatic t_switch();
        span(0, 200);
        span(1, 20);
        span(0, 200);
        check_range(n, 36, 46);
        on_cyc <= 8'h14;
        span(1, 100);
        span(0, 200);
        span(1, 100);
        check_range(n, 20, 28);
        span(0, 100);
        check_range(n, 10, 18);
        on_cyc <= 8'h64;
        span(0, 200);
        cap <= 1'b1;
        span(1, 10);
        check_range(n, 2, 5);
        cap <= 1'b0;
        span(0, 200);
        oc <= 1'b1;
        span(1, 10);
        check_range(n, 2, 5);
        oc <= 1'b0;
        span(0, 1000);
        check_range(n, 796, 812);
    endtask
    task automatic t_clamp();
        on_cyc <= 8'h14;
        // each power-limit edge lands one step below the previous clamp, floor at the lowest
        for (int k = 5; k >= -2; k--) begin
            plim <= 1'b1;
            @(posedge core_clk);
            plim <= 1'b0;
            repeat (4) @(posedge core_clk);
            check(32'(clamp), 32'((k < 0) ? 0 : k));
        end
        check(32'(clamp), 32'h0);
        for (int k = 1; k <= 6; k++) begin
            for (n = 0; n < 100 && clamp === 3'(k - 1); n++) @(posedge core_clk);
            check(32'(clamp), 32'(k));
        end
    endtask
    task automatic t_standby();
        mode_a <= 1'b1;
        mode_b <= 1'b1;
        repeat (40) @(posedge core_clk);
        mode_a <= 1'b0;
        rms_ok <= 1'b1;
        rail_lo <= 1'b1;
        span(0, 400);
        check_range(n, 95, 215);
        check(32'(clamp), 32'h0);
        rail_lo <= 1'b0;
        rail_hi <= 1'b1;
        repeat (40) @(posedge core_clk);
        span(0, 150);
        check_range(n, 150, 150);
        rail_hi <= 1'b0;
        mode_b <= 1'b0;
        span(0, 100);
        check_range(n, 0, 60);
        // rapid start-up runs continuously as well
        mode_a <= 1'b1;
        repeat (10) @(posedge core_clk);
        bus(1'b0, 4'h4, 32'h0);
        check(32'(rdata[11:8]), 32'h8);
    endtask
    task automatic t_recover();
        rms_hi <= 1'b1;
        line_p <= 1'b0;
        line_s <= 1'b0;
        repeat (400) @(posedge core_clk);
        bus(1'b0, 4'h4, 32'h0);
        check(32'(rdata[4:2]), 32'h3);
        repeat (170) @(posedge core_clk);
        bus(1'b0, 4'h4, 32'h0);
        check(32'(rdata[4]), 32'h1);
        span(1, 50);
        span(0, 300);
        check_range(n, 300, 300);
        // enough margin past twenty ticks whatever the divider phase
        repeat (160) @(posedge core_clk);
        check(32'(hold), 32'h1);
        line_p <= 1'b1;
        line_s <= 1'b1;
        repeat (6) @(posedge core_clk);
        check(32'(hold), 32'h0);
        span(0, 100);
        check_range(n, 0, 60);
        line_p <= 1'b0;
        line_s <= 1'b0;
        repeat (200) @(posedge core_clk);
        line_s <= 1'b1;
        repeat (500) @(posedge core_clk);
        bus(1'b0, 4'h4, 32'h0);
        check(32'(rdata[4]), 32'h0);
        line_p <= 1'b1;
        rms_hi <= 1'b0;
        repeat (20) @(posedge core_clk);
        line_p <= 1'b0;
        line_s <= 1'b0;
        repeat (700) @(posedge core_clk);
        bus(1'b0, 4'h4, 32'h0);
        check(32'({rdata[4], rdata[2]}), 32'h0);
    endtask
    // ----------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #100us;
        err_total++;
        end_of_test();
    end
    initial begin
        {rd, wr, mode_a, mode_b, rail_lo, rail_hi, rms_ok, rms_hi, cap, oc, plim} = 11'h0;
        {line_p, line_s, rst} = 3'h7;
        addr = 4'h0;
        wdata = 32'h0;
        on_cyc = 8'h00;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_switch();
        t_clamp();
        t_standby();
        t_recover();
        end_of_test();
    end
endmodule // tb_top
